/* File: hw/ebp_pkg.sv */
`default_nettype none
package ebp_pkg;
   // ==========================================================
   // register map
   localparam int ADDR_W = 12;
   localparam int REG_COUNT = 8;
   localparam logic [11:0] OFF_HIGH_DIR = 12'h000;
   localparam logic [11:0] OFF_HIGH_PINS = 12'h004;
   localparam logic [11:0] OFF_HIGH_LATCH = 12'h008;
   localparam logic [11:0] OFF_ANALOG_CFG = 12'h00C;
   localparam logic [11:0] OFF_MEM_CTRL = 12'h010;
   localparam logic [11:0] OFF_CTRL_DIR = 12'h014;
   localparam logic [11:0] OFF_CTRL_PINS = 12'h018;
   localparam logic [11:0] OFF_CTRL_LATCH = 12'h01C;
   localparam logic [2:0] IDX_HIGH_DIR = 3'h0;
   localparam logic [2:0] IDX_HIGH_PINS = 3'h1;
   localparam logic [2:0] IDX_HIGH_LATCH = 3'h2;
   localparam logic [2:0] IDX_ANALOG_CFG = 3'h3;
   localparam logic [2:0] IDX_MEM_CTRL = 3'h4;
   localparam logic [2:0] IDX_CTRL_DIR = 3'h5;
   localparam logic [2:0] IDX_CTRL_PINS = 3'h6;
   localparam logic [2:0] IDX_CTRL_LATCH = 3'h7;
   // ==========================================================
   // fields and reset values
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] MBC_RESET = 8'h00;
   localparam logic [7:0] MBC_MASK = 8'hB3;
   localparam int MBC_BUS_DISABLE_BIT = 7;
   localparam int MBC_WAIT_LSB = 4;
   localparam int MBC_WMODE_LSB = 0;
   localparam logic [7:0] APC_RESET = 8'h00;
   localparam logic [7:0] APC_MASK = 8'h3F;
   localparam int APC_SELECT_LSB = 0;
   localparam int APC_VREF_LSB = 4;
   // ==========================================================
   // high port pin roles
   localparam int HP_ADDR_LSB = 0;
   localparam int HP_ANALOG_LSB = 4;
   localparam int HP_PWM_C_BIT = 6;
   localparam int HP_PWM_B_BIT = 7;
   localparam logic [3:0] ANALOG_CH_FIRST = 4'hC;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } ebp_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ebp_apb_rsp_t;
   // bit 0 is the address latch enable, bit 7 the upper byte select
   typedef struct packed {
      logic upper_byte_select;
      logic lower_byte_select;
      logic chip_enable;
      logic byte_address_bit;
      logic write_strobe_high_byte;
      logic write_strobe_low_byte;
      logic output_enable;
      logic address_latch_enable;
   } ebp_emi_ctrl_t;
   // bit 3 flags a hit, bits 2:0 give the register index
   function automatic logic [3:0] ebp_decode(input logic [ADDR_W-1:0] addr);
      logic [3:0] hit;
      hit = 4'h0;
      if (addr[1:0] == 2'h0 && addr[ADDR_W-1:5] == '0) begin
         hit = {1'b1, addr[4:2]};
      end
      return hit;
   endfunction
endpackage
`default_nettype wire

/* File: hw/ebp_port8.sv */
`timescale 1ns/10ps
`default_nettype none
module ebp_port8 #(
   parameter int WIDTH = 8
) (
   // clock and resets
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_rst_other,
   // register writes
   input wire logic i_wr_dir,
   input wire logic i_wr_latch,
   input wire logic [WIDTH-1:0] i_wdata,
   // peripheral overrides
   input wire logic [WIDTH-1:0] i_alt_en,
   input wire logic [WIDTH-1:0] i_alt_out,
   input wire logic [WIDTH-1:0] i_force_in,
   // pins
   input wire logic [WIDTH-1:0] i_pin_in,
   output logic [WIDTH-1:0] o_pin_out,
   output logic [WIDTH-1:0] o_pin_oe_n,
   // register state
   output logic [WIDTH-1:0] o_dir,
   output logic [WIDTH-1:0] o_latch,
   output logic [WIDTH-1:0] o_pin_read
);
   generate
      if (WIDTH < 1 || WIDTH > 8) begin : g_bad
         $error("ebp_port8 width must be 1 to 8");
      end
   endgenerate
   // ==========================================================
   // direction: back to all inputs on every reset
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_dir <= ebp_pkg::DIR_RESET[WIDTH-1:0]; // RQ9
      end else if (i_rst_other) begin
         o_dir <= ebp_pkg::DIR_RESET[WIDTH-1:0]; // RQ19
      end else if (i_wr_dir) begin
         o_dir <= i_wdata; // RQ8
      end
   end
   // ==========================================================
   // output latch: kept across the other resets
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_latch <= ebp_pkg::LATCH_RESET[WIDTH-1:0];
      end else if (i_wr_latch) begin
         o_latch <= i_wdata; // RQ18 RQ19
      end
   end
   // ==========================================================
   // pin drivers
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pin_out <= '0;
         o_pin_oe_n <= '1;
      end else begin
         o_pin_out <= (i_alt_en & i_alt_out) | (~i_alt_en & o_latch); // RQ2
         o_pin_oe_n <= i_force_in | (~i_alt_en & o_dir); // RQ1 RQ7
      end
   end
   assign o_pin_read = i_pin_in & ~i_force_in;
endmodule
`default_nettype wire

/* File: hw/ebp_apb_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module ebp_apb_slave #(
   parameter int REGS = 8
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // apb
   input wire ebp_pkg::ebp_apb_req_t i_apb,
   output ebp_pkg::ebp_apb_rsp_t o_apb,
   // register side
   input wire logic [REGS-1:0][7:0] i_rdata,
   output logic [REGS-1:0] o_wr_en,
   output logic [7:0] o_wdata
);
   generate
      if (REGS != ebp_pkg::REG_COUNT) begin : g_bad
         $error("ebp_apb_slave register count mismatch");
      end
   endgenerate
   logic [3:0] wr_hit;
   logic [3:0] rd_hit;
   logic [7:0] prdata;
   logic pslverr;
   assign wr_hit = ebp_pkg::ebp_decode(i_apb.paddr);
   assign rd_hit = wr_hit;
   // ==========================================================
   // writes land at the access edge; zero wait states
   always_comb begin
      o_wr_en = '0;
      if (i_apb.psel && i_apb.penable && i_apb.pwrite && wr_hit[3]) begin
         o_wr_en[wr_hit[2:0]] = 1'b1;
      end
   end
   assign o_wdata = i_apb.pwdata[7:0];
   // ==========================================================
   // read data and error are taken at the setup edge
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         prdata <= 8'h00;
         pslverr <= 1'b0;
      end else if (i_apb.psel && !i_apb.penable) begin
         prdata <= (rd_hit[3] && !i_apb.pwrite) ? i_rdata[rd_hit[2:0]] : 8'h00;
         pslverr <= !rd_hit[3];
      end
   end
   assign o_apb.prdata = {24'h000000, prdata};
   assign o_apb.pready = 1'b1;
   assign o_apb.pslverr = pslverr;
endmodule
`default_nettype wire

/* File: hw/ebp_shared_io.sv */
// Overview of operation
// RQ1 - direction one tristates the pin
// RQ2 - direction zero drives the output latch
// RQ3 - latch register reads latch, not pins
// RQ4 - control port is GPIO only with bus off
// RQ5 - bits 0-3: latch enable, read, write strobes
// RQ6 - bits 4-7: byte address, chip, byte selects
// RQ7 - peripherals may force pin direction
// RQ8 - forced direction never stored in register
// RQ9 - power-on reset makes control pins inputs
// RQ10 - bus mode: high bits 0-3 are address 16-19
// RQ11 - high bits 4-7 are analog channels 12-15
// RQ12 - remap cleared: bits 6,7 carry pwm c,b
// RQ13 - memory control held reset in microcontroller mode
// RQ14 - memory control picks address or GPIO
// RQ15 - analog config picks analog or digital
// RQ16 - default: analog inputs and address pins
// RQ17 - analog pins read zero on pin register
// RQ18 - pins register reads pins, writes latch
// RQ19 - latches survive other resets, directions don't
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ebp_shared_io (
   // clock and resets
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   input wire logic i_rst_other,
   // device mode
   input wire logic i_microcontroller_mode,
   // register bus
   input wire ebp_pkg::ebp_apb_req_t i_apb,
   output ebp_pkg::ebp_apb_rsp_t o_apb,
   // memory interface signals from the bus controller
   input wire ebp_pkg::ebp_emi_ctrl_t i_emi_ctrl,
   input wire logic [3:0] i_emi_addr_upper,
   // pwm unit
   input wire logic i_pwm_pin_remap_config,
   input wire logic i_pwm_enable,
   input wire logic i_pwm_output_b,
   input wire logic i_pwm_output_c,
   // high-address port pins
   input wire logic [7:0] i_high_pin_in,
   output logic [7:0] o_high_pin_out,
   output logic [7:0] o_high_pin_oe_n,
   // control port pins
   input wire logic [7:0] i_ctrl_pin_in,
   output logic [7:0] o_ctrl_pin_out,
   output logic [7:0] o_ctrl_pin_oe_n,
   // configuration to the bus controller and converter
   output logic o_system_bus_mode,
   output logic [1:0] o_wait_state,
   output logic [1:0] o_write_mode,
   output logic [1:0] o_vref_config,
   output logic [3:0] o_analog_select
);
   // ==========================================================
   // local signals
   logic [7:0] memory_bus_control;
   logic [7:0] analog_pin_config;
   logic [ebp_pkg::REG_COUNT-1:0] wr_en;
   logic [7:0] wdata;
   logic [ebp_pkg::REG_COUNT-1:0][7:0] rdata;

   // pin roles
   logic bus_active;
   logic [3:0] analog_sel;
   logic [7:0] high_alt_en;
   logic [7:0] high_alt_out;
   logic [7:0] high_force_in;
   logic [7:0] ctrl_alt_en;
   logic [7:0] ctrl_alt_out;

   // port register state
   logic [7:0] high_port_direction;
   logic [7:0] high_port_latch;
   logic [7:0] high_port_pins;
   logic [7:0] control_port_direction;
   logic [7:0] control_port_latch;
   logic [7:0] control_port_pins;

   // register fields and pwm gating
   logic external_bus_disable;
   logic [3:0] analog_pin_select_field;
   logic pwm_on_pins;

   // ==========================================================
   // register bus slave
   ebp_apb_slave #(
      .REGS(ebp_pkg::REG_COUNT)
   ) u_apb (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_apb(i_apb),
      .o_apb(o_apb),
      .i_rdata(rdata),
      .o_wr_en(wr_en),
      .o_wdata(wdata)
   );

   // ==========================================================
   // memory bus control register
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         memory_bus_control <= ebp_pkg::MBC_RESET;
      end else if (i_microcontroller_mode) begin
         memory_bus_control <= ebp_pkg::MBC_RESET; // RQ13
      end else if (i_rst_other) begin
         memory_bus_control <= ebp_pkg::MBC_RESET;
      end else if (wr_en[ebp_pkg::IDX_MEM_CTRL]) begin
         memory_bus_control <= wdata & ebp_pkg::MBC_MASK;
      end
   end

   assign external_bus_disable = memory_bus_control[ebp_pkg::MBC_BUS_DISABLE_BIT];

   // ==========================================================
   // analog pin configuration register
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         analog_pin_config <= ebp_pkg::APC_RESET; // RQ16
      end else if (i_rst_other) begin
         analog_pin_config <= ebp_pkg::APC_RESET;
      end else if (wr_en[ebp_pkg::IDX_ANALOG_CFG]) begin
         analog_pin_config <= wdata & ebp_pkg::APC_MASK;
      end
   end

   assign analog_pin_select_field =
      analog_pin_config[ebp_pkg::APC_SELECT_LSB +: 4];

   // ==========================================================
   // pin role selection
   // the external bus runs unless disabled or in microcontroller mode
   assign bus_active = !i_microcontroller_mode && !external_bus_disable; // RQ14 RQ16

   // channel 12+k is analog while the select field is at most 3-k
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_analog
         assign analog_sel[k] =
            analog_pin_select_field <= (4'hF - ebp_pkg::ANALOG_CH_FIRST - 4'(k)); // RQ15
      end
   endgenerate

   assign pwm_on_pins = i_pwm_enable && !i_pwm_pin_remap_config;

   // ==========================================================
   // high-address port overrides
   always_comb begin
      high_alt_en = 8'h00;
      high_alt_out = 8'h00;
      high_force_in = 8'h00;

      // address bits 16 to 19 while the bus runs
      if (bus_active) begin
         high_alt_en[ebp_pkg::HP_ADDR_LSB +: 4] = 4'hF; // RQ10
         high_alt_out[ebp_pkg::HP_ADDR_LSB +: 4] = i_emi_addr_upper; // RQ10
      end

      // analog channels hold their pins as inputs
      high_force_in[ebp_pkg::HP_ANALOG_LSB +: 4] = analog_sel; // RQ11 RQ7

      // pwm outputs win over analog forcing
      if (pwm_on_pins) begin
         high_alt_en[ebp_pkg::HP_PWM_C_BIT] = 1'b1; // RQ12
         high_alt_out[ebp_pkg::HP_PWM_C_BIT] = i_pwm_output_c; // RQ12
         high_force_in[ebp_pkg::HP_PWM_C_BIT] = 1'b0;
         high_alt_en[ebp_pkg::HP_PWM_B_BIT] = 1'b1; // RQ12
         high_alt_out[ebp_pkg::HP_PWM_B_BIT] = i_pwm_output_b; // RQ12
         high_force_in[ebp_pkg::HP_PWM_B_BIT] = 1'b0;
      end
   end

   // ==========================================================
   // control port overrides
   always_comb begin
      ctrl_alt_en = 8'h00;
      ctrl_alt_out = 8'h00;

      // the bus controller owns every control pin while the bus runs
      if (bus_active) begin
         ctrl_alt_en = 8'hFF; // RQ4
         ctrl_alt_out = i_emi_ctrl; // RQ5 RQ6
      end
   end

   // ==========================================================
   // high-address port
   ebp_port8 #(
      .WIDTH(8)
   ) u_high (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_rst_other(i_rst_other),
      // register writes
      .i_wr_dir(wr_en[ebp_pkg::IDX_HIGH_DIR]),
      .i_wr_latch(wr_en[ebp_pkg::IDX_HIGH_PINS] | wr_en[ebp_pkg::IDX_HIGH_LATCH]),
      .i_wdata(wdata),
      // peripheral overrides
      .i_alt_en(high_alt_en),
      .i_alt_out(high_alt_out),
      .i_force_in(high_force_in),
      // pins
      .i_pin_in(i_high_pin_in),
      .o_pin_out(o_high_pin_out),
      .o_pin_oe_n(o_high_pin_oe_n),
      // register state
      .o_dir(high_port_direction),
      .o_latch(high_port_latch),
      .o_pin_read(high_port_pins)
   );

   // ==========================================================
   // control port
   ebp_port8 #(
      .WIDTH(8)
   ) u_ctrl (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_rst_other(i_rst_other),
      // register writes
      .i_wr_dir(wr_en[ebp_pkg::IDX_CTRL_DIR]),
      .i_wr_latch(wr_en[ebp_pkg::IDX_CTRL_PINS] | wr_en[ebp_pkg::IDX_CTRL_LATCH]),
      .i_wdata(wdata),
      // peripheral overrides
      .i_alt_en(ctrl_alt_en),
      .i_alt_out(ctrl_alt_out),
      .i_force_in(8'h00),
      // pins
      .i_pin_in(i_ctrl_pin_in),
      .o_pin_out(o_ctrl_pin_out),
      .o_pin_oe_n(o_ctrl_pin_oe_n),
      // register state
      .o_dir(control_port_direction),
      .o_latch(control_port_latch),
      .o_pin_read(control_port_pins)
   );

   // ==========================================================
   // read-back
   always_comb begin
      rdata = '0;

      // high-address port
      rdata[ebp_pkg::IDX_HIGH_DIR] = high_port_direction; // RQ8
      rdata[ebp_pkg::IDX_HIGH_PINS] = high_port_pins; // RQ17 RQ18
      rdata[ebp_pkg::IDX_HIGH_LATCH] = high_port_latch; // RQ3

      // configuration
      rdata[ebp_pkg::IDX_ANALOG_CFG] = analog_pin_config;
      rdata[ebp_pkg::IDX_MEM_CTRL] = memory_bus_control;

      // control port
      rdata[ebp_pkg::IDX_CTRL_DIR] = control_port_direction; // RQ8
      rdata[ebp_pkg::IDX_CTRL_PINS] = control_port_pins; // RQ18
      rdata[ebp_pkg::IDX_CTRL_LATCH] = control_port_latch; // RQ3
   end

   // ==========================================================
   // configuration outputs: bus mode
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_system_bus_mode <= 1'b0;
      end else begin
         o_system_bus_mode <= bus_active; // RQ14
      end
   end

   // ==========================================================
   // configuration outputs: memory timing
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wait_state <= 2'h0;
      end else begin
         o_wait_state <= memory_bus_control[ebp_pkg::MBC_WAIT_LSB +: 2];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_write_mode <= 2'h0;
      end else begin
         o_write_mode <= memory_bus_control[ebp_pkg::MBC_WMODE_LSB +: 2];
      end
   end

   // ==========================================================
   // configuration outputs: converter
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_vref_config <= 2'h0;
      end else begin
         o_vref_config <= analog_pin_config[ebp_pkg::APC_VREF_LSB +: 2];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_analog_select <= 4'h0;
      end else begin
         o_analog_select <= analog_sel; // RQ15
      end
   end
endmodule
`default_nettype wire

/* File: sim/ebp_shared_io_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ebp_shared_io_chk (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // stimulus seen by the block
   input wire logic i_rst_other,
   input wire logic i_microcontroller_mode,
   input wire ebp_pkg::ebp_apb_req_t i_apb,
   input wire ebp_pkg::ebp_emi_ctrl_t i_emi_ctrl,
   input wire logic [3:0] i_emi_addr_upper,
   input wire logic i_pwm_pin_remap_config,
   input wire logic i_pwm_enable,
   input wire logic i_pwm_output_b,
   input wire logic i_pwm_output_c,
   // block outputs
   input wire ebp_pkg::ebp_apb_rsp_t o_apb,
   input wire logic [7:0] o_high_pin_out,
   input wire logic [7:0] o_high_pin_oe_n,
   input wire logic [7:0] o_ctrl_pin_out,
   input wire logic [7:0] o_ctrl_pin_oe_n,
   input wire logic o_system_bus_mode,
   input wire logic [1:0] o_wait_state,
   input wire logic [1:0] o_write_mode,
   input wire logic [3:0] o_analog_select
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);
   logic setup;
   assign setup = i_apb.psel && !i_apb.penable;
   // ======
   // pin roles
   chk_ctrl_bus_pins: assert property (o_system_bus_mode |->
      o_ctrl_pin_oe_n == 8'h00 && o_ctrl_pin_out == $past(i_emi_ctrl))
      else $error("control pins do not follow memory strobes");
   chk_high_addr_pins: assert property (o_system_bus_mode |->
      o_high_pin_oe_n[3:0] == 4'h0 && o_high_pin_out[3:0] == $past(i_emi_addr_upper))
      else $error("high pins do not carry upper address");
   chk_pwm_alt_pins: assert property (i_pwm_enable && !i_pwm_pin_remap_config |=>
      o_high_pin_oe_n[7:6] == 2'b00 &&
      o_high_pin_out[7:6] == {$past(i_pwm_output_b), $past(i_pwm_output_c)})
      else $error("pwm outputs missing on high pins");
   chk_default_roles: assert property ($rose(i_nrst) && !i_microcontroller_mode &&
      !i_pwm_enable |=> o_system_bus_mode && o_analog_select == 4'hF &&
      o_high_pin_oe_n[7:4] == 4'hF)
      else $error("default pin roles wrong after reset");
   // ======
   // configuration resets
   chk_micro_mode_hold: assert property (i_microcontroller_mode[*3] |->
      !o_system_bus_mode && o_wait_state == 2'h0 && o_write_mode == 2'h0)
      else $error("memory control not held in microcontroller mode");
   chk_other_reset: assert property (i_rst_other |=> ##1
      o_analog_select == 4'hF && o_wait_state == 2'h0 && o_write_mode == 2'h0)
      else $error("other reset did not clear configuration");
   // ======
   // register bus
   chk_unmapped_err: assert property (setup &&
      (i_apb.paddr >= 12'h020 || i_apb.paddr[1:0] != 2'h0) |=>
      o_apb.pslverr && o_apb.prdata == 32'h0)
      else $error("unmapped access not refused");
   chk_mapped_ok: assert property (setup && i_apb.paddr < 12'h020 &&
      i_apb.paddr[1:0] == 2'h0 |=> !o_apb.pslverr && o_apb.prdata[31:8] == 24'h0)
      else $error("mapped access answered wrongly");
   chk_write_rdata: assert property (setup && i_apb.pwrite |=>
      o_apb.prdata == 32'h0)
      else $error("write returned read data");
   cover property (setup && i_apb.paddr >= 12'h020);
   cover property (i_pwm_enable && !i_pwm_pin_remap_config);
   cover property (i_microcontroller_mode[*3]);
endmodule
bind ebp_shared_io ebp_shared_io_chk i_chk (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
   .i_rst_other(i_rst_other), .i_microcontroller_mode(i_microcontroller_mode),
   .i_apb(i_apb), .i_emi_ctrl(i_emi_ctrl), .i_emi_addr_upper(i_emi_addr_upper),
   .i_pwm_pin_remap_config(i_pwm_pin_remap_config), .i_pwm_enable(i_pwm_enable),
   .i_pwm_output_b(i_pwm_output_b), .i_pwm_output_c(i_pwm_output_c), .o_apb(o_apb),
   .o_high_pin_out(o_high_pin_out), .o_high_pin_oe_n(o_high_pin_oe_n),
   .o_ctrl_pin_out(o_ctrl_pin_out), .o_ctrl_pin_oe_n(o_ctrl_pin_oe_n),
   .o_system_bus_mode(o_system_bus_mode), .o_wait_state(o_wait_state),
   .o_write_mode(o_write_mode), .o_analog_select(o_analog_select));
`default_nettype wire

/* File: sim/ebp_board_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ebp_board_model (
   // clock
   input wire logic i_clk_sys,
   // levels the board drives where the device lets go
   input wire logic [7:0] i_ext_val,
   input wire logic [7:0] i_ext_en,
   // device side of one port
   input wire logic [7:0] i_pin_out,
   input wire logic [7:0] i_pin_oe_n,
   output logic [7:0] o_pin
);
   logic [7:0] churn = 8'h00;
   // the churn value feeding floating bits changes every cycle so stale data never looks valid
   always_ff @(posedge i_clk_sys) churn <= churn + 8'h55;
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         o_pin[b] = !i_pin_oe_n[b] ? i_pin_out[b] : (i_ext_en[b] ? i_ext_val[b] : churn[b]);
      end
   end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, nrst = 1'b0, rst_o = 1'b0, mc = 1'b0;
   logic pwm_en = 1'b0, remap = 1'b1, pb = 1'b1, pc = 1'b0, bus_mode, err;
   logic [3:0] addr_up = 4'hA;
   logic [3:0] asel;
   ebp_pkg::ebp_emi_ctrl_t emi = 8'h5C;
   ebp_pkg::ebp_apb_req_t apb = '0;
   ebp_pkg::ebp_apb_rsp_t rsp;
   logic [7:0] h_out, h_oe, c_out, c_oe, h_in, c_in;
   logic [1:0] wst, wmd, vref;
   logic [31:0] rd;
   logic [11:0] radr [6] = '{12'h000, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h01C};
   logic [7:0] rrst [6] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
   int mismatches = 0, compares = 0;
   always #10 clk = ~clk;
   ebp_shared_io i_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_rst_other(rst_o),
      .i_microcontroller_mode(mc), .i_apb(apb), .o_apb(rsp), .i_emi_ctrl(emi),
      .i_emi_addr_upper(addr_up), .i_pwm_pin_remap_config(remap), .i_pwm_enable(pwm_en),
      .i_pwm_output_b(pb), .i_pwm_output_c(pc), .i_high_pin_in(h_in),
      .o_high_pin_out(h_out), .o_high_pin_oe_n(h_oe), .i_ctrl_pin_in(c_in),
      .o_ctrl_pin_out(c_out), .o_ctrl_pin_oe_n(c_oe), .o_system_bus_mode(bus_mode),
      .o_wait_state(wst), .o_write_mode(wmd), .o_vref_config(vref), .o_analog_select(asel));
   ebp_board_model i_hbrd (.i_clk_sys(clk), .i_ext_val(8'hFF), .i_ext_en(8'hFF),
      .i_pin_out(h_out), .i_pin_oe_n(h_oe), .o_pin(h_in));
   ebp_board_model i_cbrd (.i_clk_sys(clk), .i_ext_val(8'h3C), .i_ext_en(8'hFF),
      .i_pin_out(c_out), .i_pin_oe_n(c_oe), .o_pin(c_in));
   // ======
   // access tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}};
      @(posedge clk);
      apb.penable <= 1'b1;
      // only the watchdog ends a wait for the slave
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      apb.psel <= 1'b0;
      apb.penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [7:0] e);
      xfer(a, 1'b0, 8'h00);
      check(rd, 32'(e));
   endtask
   // writes reach the pins through the latch and registered drivers
   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic pins(input logic [7:0] ho, hoe, co, coe);
      settle();
      check(32'(h_oe), 32'(hoe));
      check(32'(h_out & ~h_oe), 32'(ho));
      check(32'(c_oe), 32'(coe));
      check(32'(c_out & ~c_oe), 32'(co));
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      tally_and_finish();
   end
   // ======
   // tests
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) rchk(radr[i], rrst[i]);
      pins(8'h0A, 8'hF0, 8'h5C, 8'h00);
      @(posedge clk);
      emi <= 8'hA3;
      addr_up <= 4'h5;
      pins(8'h05, 8'hF0, 8'hA3, 8'h00);
      rchk(12'h004, 8'h05);
      wr(12'h010, 8'hFF);
      rchk(12'h010, 8'hB3);
      pins(8'h00, 8'hFF, 8'h00, 8'hFF);
      check(32'({bus_mode, wst, wmd}), 32'h0F);
      rchk(12'h018, 8'h3C);
      wr(12'h018, 8'h96);
      rchk(12'h01C, 8'h96);
      rchk(12'h018, 8'h3C);
      wr(12'h014, 8'h0F);
      pins(8'h00, 8'hFF, 8'h90, 8'h0F);
      rchk(12'h018, 8'h9C);
      rchk(12'h014, 8'h0F);
      for (int s = 0; s < 5; s++) begin
         wr(12'h00C, 8'(s));
         settle();
         check(32'(asel), 32'(4'hF >> s));
      end
      wr(12'h00C, 8'hFF);
      rchk(12'h00C, 8'h3F);
      check(32'(vref), 32'h3);
      wr(12'h004, 8'h5A);
      rchk(12'h008, 8'h5A);
      wr(12'h000, 8'h00);
      pins(8'h5A, 8'h00, 8'h90, 8'h0F);
      rchk(12'h004, 8'h5A);
      wr(12'h000, 8'hFF);
      @(posedge clk);
      pwm_en <= 1'b1;
      remap <= 1'b0;
      pins(8'h80, 8'h3F, 8'h90, 8'h0F);
      rchk(12'h000, 8'hFF);
      @(posedge clk);
      remap <= 1'b1;
      pins(8'h00, 8'hFF, 8'h90, 8'h0F);
      xfer(12'h020, 1'b1, 8'h77);
      check(32'(err), 32'h1);
      xfer(12'h006, 1'b0, 8'h00);
      check({rd[30:0], err}, 32'h1);
      rchk(12'h008, 8'h5A);
      check(32'(err), 32'h0);
      @(posedge clk);
      rst_o <= 1'b1;
      @(posedge clk);
      rst_o <= 1'b0;
      rchk(12'h008, 8'h5A);
      rchk(12'h014, 8'hFF);
      rchk(12'h010, 8'h00);
      settle();
      check(32'({bus_mode, asel}), 32'h1F);
      @(posedge clk);
      mc <= 1'b1;
      wr(12'h010, 8'h33);
      rchk(12'h010, 8'h00);
      settle();
      check(32'({bus_mode, wst, wmd}), 32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
